//--- rtl/nab_consts.svh
`ifndef NAB_CONSTS_SVH
`define NAB_CONSTS_SVH
// Timer tick and timing widths.
`define NAB_CLK_MHZ        250
`define NAB_TICK_US        1
`define NAB_TICK_CYC       (`NAB_CLK_MHZ * `NAB_TICK_US)
`define NAB_TICK_CW        8
`define NAB_TW             20
`define NAB_PKT_B_MAX_MS   250
`define NAB_PKT_B_MAX      (`NAB_PKT_B_MAX_MS * 1000 / `NAB_TICK_US)
// Address field handling.
`define NAB_AW             8
`define NAB_NDEST          16
`define NAB_IW             5
`define NAB_ADDR_RSVD      8'h00
`define NAB_ADDR_SP1       8'h01
`define NAB_ADDR_SP2       8'h02
`define NAB_ADDR_SP3       8'h03
`endif

//--- rtl/nab_pkg.sv
package nab_pkg;
  typedef enum logic [1:0] {
    NAB_IDLE = 2'b00,
    NAB_LAG  = 2'b01,
    NAB_RUN  = 2'b10
  } nab_phase_t;

  typedef struct packed {
    logic [19:0] preamble;
    logic [19:0] lag;
    logic [19:0] busy_param;
    logic [19:0] tolerance_time;
    logic [19:0] time_a;
    logic [19:0] ack_len;
    logic [19:0] turn;
    logic [19:0] ack_prep;
  } nab_params_t;

  typedef struct packed {
    logic       busy;
    logic       tx_grant;
    nab_phase_t phase;
    logic [19:0] lag_cnt;
    logic [7:0]  tick_cnt;
    logic [19:0] hold_cnt;
    logic [19:0] tp_cnt;
    logic        hold_run;
    logic        tp_run;
    logic        hold_done;
    logic        tp_done;
    logic        own_found;
    logic [19:0] hold_delay;
    logic [19:0] tp_value;
    logic [19:0] detect_time;
  } nab_state_t;
endpackage : nab_pkg

//--- rtl/nab_timers.sv
`timescale 1ns/1ns
`include "nab_consts.svh"
// Contract
// - Busy clears only when neither voice nor data is detected.
// - No voice detected means voice never makes the net busy.
// - Voice busy sets the link busy indicator.
// - Busy indicator inhibits all transmissions, coupled responses too.
// - All stations use the same data busy detect time.
// - Formula detect time is default when no measured value exists.
// - Earlier equipment busy signal is used for busy sensing.
// - Without special capability, received data itself signals busy.
// - Detect time is preamble plus lag plus busy parameter plus tolerance.
// - Hold delay chosen from own address position in destinations.
// - Reserved address 0 is ignored and takes no position.
// - Hold delay timer starts exactly at end of equipment lag.
// - All subnet stations use identical hold delay parameters.
// - Base slot sums preamble, time_a, ack length, lag, turn, tolerance.
// - Timeout is j times base slot plus tolerance plus max(ackprep,turn).
// - Sender excludes special address 3; values held in exact ticks.
// - Hold delay is (i-1) slots plus max(ackprep,turn) plus tolerance.
// - Timeout must expire before access delay is scheduled.
// - Sender waits for expected acknowledgements during the timeout.
// - Timeout parameters identical on subnet except immediate retransmit.
// - Retransmit sender counts 1 and 2; receivers count 1, 2 and 3.
// - Timeout timer starts exactly when equipment lag ends.
// - Data busy sets the same indicator as voice busy.
// - In packet mode busy parameter is limited to 250 ms.
module nab_timers (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire nab_pkg::nab_params_t    params_in,
  input  wire logic                    measured_valid_in,
  input  wire logic [`NAB_TW-1:0]      measured_detect_in,
  input  wire logic                    packet_mode_in,
  input  wire logic                    voice_detect_in,
  input  wire logic                    carrier_detect_in,
  input  wire logic                    early_busy_valid_in,
  input  wire logic                    data_detect_in,
  input  wire logic                    tx_request_in,
  input  wire logic                    frame_end_in,
  input  wire logic                    is_sender_in,
  input  wire logic                    immed_retx_in,
  input  wire logic [`NAB_AW-1:0]      own_addr_in,
  input  wire logic [`NAB_NDEST*`NAB_AW-1:0] dest_addrs_in,
  input  wire logic [`NAB_NDEST-1:0]   dest_valid_in,
  output logic                         busy_out,
  output logic                         tx_grant_out,
  output logic                         hold_expired_out,
  output logic                         tp_expired_out,
  output logic                         addressed_out,
  output logic [`NAB_TW-1:0]           hold_delay_out,
  output logic [`NAB_TW-1:0]           timeout_out,
  output logic [`NAB_TW-1:0]           detect_time_out
);

  // ----------------------------------------------------------------
  // Arithmetic helpers.
  // ----------------------------------------------------------------
  function automatic logic [`NAB_TW-1:0] max2(
    input logic [`NAB_TW-1:0] a,
    input logic [`NAB_TW-1:0] b
  );
    max2 = (a > b) ? a : b;
  endfunction : max2

  function automatic logic [`NAB_TW-1:0] sat_add(
    input logic [`NAB_TW-1:0] a,
    input logic [`NAB_TW-1:0] b
  );
    logic [`NAB_TW:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[`NAB_TW] ? '1 : s[`NAB_TW-1:0];
  endfunction : sat_add

  // ----------------------------------------------------------------
  // Derived timing values.
  // ----------------------------------------------------------------
  logic [`NAB_TW-1:0] b_lim;
  logic [`NAB_TW-1:0] base_hold_slot;
  logic [`NAB_TW-1:0] resp_margin;
  logic [`NAB_TW-1:0] calc_detect;
  logic [`NAB_IW-1:0] pos_i;
  logic [`NAB_IW-1:0] count_j;
  logic               own_hit;
  logic [`NAB_TW+`NAB_IW-1:0] prod_i;
  logic [`NAB_TW+`NAB_IW-1:0] prod_j;
  logic [`NAB_TW-1:0] hold_calc;
  logic [`NAB_TW-1:0] tp_calc;
  logic               voice_busy;
  logic               data_busy;

  always_comb
  begin
    b_lim = params_in.busy_param;
    if (packet_mode_in && b_lim > `NAB_TW'(`NAB_PKT_B_MAX))
    begin
      b_lim = `NAB_TW'(`NAB_PKT_B_MAX);
    end
    calc_detect = sat_add(sat_add(params_in.preamble, params_in.lag),
                          sat_add(b_lim, params_in.tolerance_time));
    base_hold_slot = sat_add(sat_add(sat_add(params_in.preamble,
                                             params_in.time_a),
                                     sat_add(params_in.ack_len,
                                             params_in.lag)),
                             sat_add(params_in.turn,
                                     params_in.tolerance_time));
    resp_margin = sat_add(max2(params_in.ack_prep, params_in.turn),
                          params_in.tolerance_time);
  end

  always_comb
  begin
    logic [`NAB_AW-1:0] a;
    a = '0;
    pos_i = '0;
    count_j = '0;
    own_hit = 1'b0;
    for (int k = 0; k < `NAB_NDEST; k++)
    begin
      a = dest_addrs_in[k*`NAB_AW +: `NAB_AW];
      if (dest_valid_in[k] && a != `NAB_ADDR_RSVD)
      begin
        if (!own_hit)
        begin
          pos_i = pos_i + 1'b1;
        end
        if (a == own_addr_in)
        begin
          own_hit = 1'b1;
        end
        if (immed_retx_in && is_sender_in)
        begin
          if (a != `NAB_ADDR_SP3)
          begin
            count_j = count_j + 1'b1;
          end
        end
        else if (!(is_sender_in && a == `NAB_ADDR_SP3))
        begin
          count_j = count_j + 1'b1;
        end
      end
    end
    prod_i = base_hold_slot * (own_hit ? pos_i - 1'b1 : '0);
    prod_j = base_hold_slot * count_j;
    hold_calc = sat_add(|prod_i[`NAB_TW+`NAB_IW-1:`NAB_TW] ? '1 :
                        prod_i[`NAB_TW-1:0], resp_margin);
    tp_calc = sat_add(|prod_j[`NAB_TW+`NAB_IW-1:`NAB_TW] ? '1 :
                      prod_j[`NAB_TW-1:0], resp_margin);
  end

  // ----------------------------------------------------------------
  // Busy sensing.
  // ----------------------------------------------------------------
  always_comb
  begin
    voice_busy = voice_detect_in;
    data_busy = early_busy_valid_in ? carrier_detect_in
                                    : data_detect_in;
  end

  // ----------------------------------------------------------------
  // State registers.
  // ----------------------------------------------------------------
  nab_pkg::nab_state_t st_reg;
  nab_pkg::nab_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (voice_busy || data_busy)
    begin
      st_next.busy = 1'b1;
    end
    else
    begin
      st_next.busy = 1'b0;
    end
    st_next.detect_time = measured_valid_in ? measured_detect_in
                                            : calc_detect;
    st_next.tick_cnt = (st_reg.tick_cnt == `NAB_TICK_CW'(`NAB_TICK_CYC - 1))
                       ? '0 : st_reg.tick_cnt + 1'b1;
    case (st_reg.phase)
      nab_pkg::NAB_IDLE:
      begin
        if (frame_end_in)
        begin
          st_next.phase = nab_pkg::NAB_LAG;
          st_next.lag_cnt = params_in.lag;
          st_next.hold_delay = hold_calc;
          st_next.tp_value = tp_calc;
          st_next.own_found = own_hit;
          st_next.hold_done = 1'b0;
          st_next.tp_done = 1'b0;
          st_next.tick_cnt = '0;
        end
      end
      nab_pkg::NAB_LAG:
      begin
        if (st_reg.lag_cnt == '0)
        begin
          st_next.phase = nab_pkg::NAB_RUN;
          st_next.hold_cnt = st_reg.hold_delay;
          st_next.tp_cnt = st_reg.tp_value;
          st_next.hold_run = st_reg.own_found;
          st_next.tp_run = 1'b1;
          st_next.tick_cnt = '0;
        end
        else if (st_reg.tick_cnt == `NAB_TICK_CW'(`NAB_TICK_CYC - 1))
        begin
          st_next.lag_cnt = st_reg.lag_cnt - 1'b1;
        end
      end
      nab_pkg::NAB_RUN:
      begin
        if (st_reg.tick_cnt == `NAB_TICK_CW'(`NAB_TICK_CYC - 1))
        begin
          if (st_reg.hold_run)
          begin
            if (st_reg.hold_cnt <= `NAB_TW'(1))
            begin
              st_next.hold_run = 1'b0;
              st_next.hold_done = 1'b1;
            end
            st_next.hold_cnt = st_reg.hold_cnt - 1'b1;
          end
          if (st_reg.tp_cnt <= `NAB_TW'(1))
          begin
            st_next.tp_run = 1'b0;
            st_next.tp_done = 1'b1;
            st_next.phase = nab_pkg::NAB_IDLE;
          end
          st_next.tp_cnt = st_reg.tp_cnt - 1'b1;
        end
      end
      default:
      begin
        st_next.phase = nab_pkg::NAB_IDLE;
      end
    endcase
    st_next.tx_grant = tx_request_in && !st_next.busy
                       && st_next.phase == nab_pkg::NAB_IDLE;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign busy_out = st_reg.busy;
  assign tx_grant_out = st_reg.tx_grant;
  assign hold_expired_out = st_reg.hold_done;
  assign tp_expired_out = st_reg.tp_done;
  assign addressed_out = st_reg.own_found;
  assign hold_delay_out = st_reg.hold_delay;
  assign timeout_out = st_reg.tp_value;
  assign detect_time_out = st_reg.detect_time;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_busy_clear: assert property (
    (!voice_busy && !data_busy) |=> !busy_out)
    else $error("Busy not cleared when line is quiet.");
  chk_voice_quiet: assert property (
    (!voice_detect_in && !data_busy) |=> !busy_out)
    else $error("Voice reported busy without voice.");
  chk_voice_set: assert property (
    voice_detect_in |=> busy_out)
    else $error("Voice busy did not set indicator.");
  chk_tx_inhibit: assert property (
    busy_out |-> !tx_grant_out)
    else $error("Transmit granted while busy.");
  chk_data_set: assert property (
    data_busy |=> busy_out)
    else $error("Data busy did not set indicator.");
  chk_busy_fall: assert property (
    $fell(busy_out) |-> !$past(voice_detect_in) && !$past(data_busy))
    else $error("Busy cleared while the line was active.");
  chk_early_sel: assert property (
    (early_busy_valid_in && carrier_detect_in) |=> busy_out)
    else $error("Early busy signal from equipment not used.");
  chk_data_exam: assert property (
    (!early_busy_valid_in && data_detect_in) |=> busy_out)
    else $error("Received data did not signal busy.");
  chk_carrier_ign: assert property (
    (!early_busy_valid_in && !data_detect_in && !voice_detect_in)
    |=> !busy_out)
    else $error("Carrier line used without early busy capability.");
  chk_grant_req: assert property (
    tx_grant_out |-> $past(tx_request_in))
    else $error("Transmit granted without a request.");

  // ----------------------------------------------------------------
  // Timer checks.
  // ----------------------------------------------------------------
  chk_detect_sel: assert property (
    !measured_valid_in |=> detect_time_out == $past(calc_detect))
    else $error("Detect time default not applied.");
  chk_lag_start: assert property (
    (st_reg.phase == nab_pkg::NAB_LAG && st_reg.lag_cnt == '0)
    |=> st_reg.tp_cnt == timeout_out && st_reg.tp_run)
    else $error("Timeout did not start at end of lag.");
  chk_hold_start: assert property (
    (st_reg.phase == nab_pkg::NAB_LAG && st_reg.lag_cnt == '0)
    |=> st_reg.hold_cnt == hold_delay_out)
    else $error("Hold delay did not start at end of lag.");
  chk_tp_gate: assert property (
    (st_reg.phase != nab_pkg::NAB_IDLE) |-> !tx_grant_out)
    else $error("Transmit granted before timeout expired.");
  chk_frame_take: assert property (
    (st_reg.phase == nab_pkg::NAB_IDLE && frame_end_in)
    |=> st_reg.phase == nab_pkg::NAB_LAG)
    else $error("Frame end did not start the lag interval.");
  chk_tick_wrap: assert property (
    (st_reg.tick_cnt == `NAB_TICK_CW'(`NAB_TICK_CYC - 1))
    |=> st_reg.tick_cnt == '0)
    else $error("Tick counter did not wrap at one microsecond.");
  chk_hold_own: assert property (
    hold_expired_out |-> addressed_out)
    else $error("Hold delay ended for a station not addressed.");
  chk_hold_stand: assert property (
    (hold_expired_out && !frame_end_in) |=> hold_expired_out)
    else $error("Hold expiry flag dropped before next frame.");
  chk_tp_stand: assert property (
    (tp_expired_out && !frame_end_in) |=> tp_expired_out)
    else $error("Timeout expiry flag dropped before next frame.");

  cov_voice: cover property (voice_detect_in ##1 busy_out);
  cov_grant: cover property (tx_request_in ##1 tx_grant_out);
  cov_tp_end: cover property (st_reg.tp_run ##1 tp_expired_out);
  cov_hold: cover property ($rose(hold_expired_out));
  cov_addressed: cover property (frame_end_in ##1 addressed_out);

endmodule : nab_timers

//--- verification/nab_phy_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Radio equipment model reporting voice, carrier and data activity.
// ----------------------------------------------------------------
module nab_phy_model (
  input  wire logic       clk_in,
  input  wire logic [2:0] act_in,
  output logic            voice_out,
  output logic            carrier_out,
  output logic            data_out,
  output logic            early_out
);
  // Bit 0 is voice, bit 1 is data, bit 2 marks early busy capability.
  initial
  begin
    voice_out   = 1'b0;
    carrier_out = 1'b0;
    data_out    = 1'b0;
    early_out   = 1'b0;
  end

  // A capable radio flags data on its carrier line before bits decode.
  // Without that capability the carrier line carries no meaning.
  always @(negedge clk_in)
  begin
    voice_out   <= act_in[0];
    early_out   <= act_in[2];
    carrier_out <= act_in[2] ? act_in[1] : ~carrier_out;
    data_out    <= act_in[1] & ~act_in[2];
  end
endmodule : nab_phy_model

//--- verification/tb_net_access_busy_and_hold_timers.sv
`timescale 1ns/1ns
`include "nab_consts.svh"
// ----------------------------------------------------------------
// Bench for busy sensing and hold and timeout timers.
// ----------------------------------------------------------------
module tb_net_access_busy_and_hold_timers;
  logic                 clk, rst, mv, pkt, txr, fe, snd, rtx;
  logic                 voice, carr, early, data;
  logic                 busy, grant, hexp, texp, addr;
  logic [2:0]           act;
  logic [7:0]           own;
  logic [19:0]          meas, hold, tout, dtm;
  logic [127:0]         dst;
  logic [15:0]          dv;
  nab_pkg::nab_params_t prm;
  int                   seed, mismatches, n_compared;
  logic                 hung;

  always #2 clk = ~clk;

  nab_phy_model i_phy (.clk_in(clk), .act_in(act), .voice_out(voice),
    .carrier_out(carr), .data_out(data), .early_out(early));

  nab_timers i_dut (.clk_in(clk), .rst_in(rst), .params_in(prm),
    .measured_valid_in(mv), .measured_detect_in(meas),
    .packet_mode_in(pkt), .voice_detect_in(voice),
    .carrier_detect_in(carr), .early_busy_valid_in(early),
    .data_detect_in(data), .tx_request_in(txr), .frame_end_in(fe),
    .is_sender_in(snd), .immed_retx_in(rtx), .own_addr_in(own),
    .dest_addrs_in(dst), .dest_valid_in(dv), .busy_out(busy),
    .tx_grant_out(grant), .hold_expired_out(hexp),
    .tp_expired_out(texp), .addressed_out(addr),
    .hold_delay_out(hold), .timeout_out(tout), .detect_time_out(dtm));

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Runs one frame and checks latched values and timer expiry times.
  task automatic frame(input logic s, input logic r);
    int         k, i, j, n, th, base, mx, tp, hd;
    logic [31:0] v;
    logic        gb;
    for (k = 0; k < 16; k++)
    begin
      v = $random(seed);
      dst[8*k+:8] = v[2] ? {6'h04, v[1:0]} : {6'h00, v[1:0]};
    end
    dv = 16'($random(seed) & 15);
    if (!s)
    begin
      k = $random(seed) & 3;
      dst[8*k+:8] = own;
      dv[k] = 1'b1;
    end
    i = 0;
    j = 0;
    n = 0;
    for (k = 0; k < 16; k++)
      if (dv[k] && dst[8*k+:8] != 8'h00)
      begin
        n++;
        if (dst[8*k+:8] == own)
          i = n;
        if (!(s && dst[8*k+:8] == 8'h03))
          j++;
      end
    base = prm.preamble + prm.time_a + prm.ack_len + prm.lag + prm.turn
      + prm.tolerance_time;
    mx = (prm.ack_prep > prm.turn) ? prm.ack_prep : prm.turn;
    tp = j * base + prm.tolerance_time + mx;
    hd = (i - 1) * base + mx + prm.tolerance_time;
    snd = s;
    rtx = r;
    fe = 1'b1;
    tick(1);
    fe = 1'b0;
    n = 1;
    th = 0;
    gb = 1'b0;
    while (texp !== 1'b1 && n < 12000)
    begin
      tick(1);
      n++;
      if (hexp === 1'b1 && th == 0)
        th = n;
      gb = gb | (grant & ~texp);
    end
    if (n >= 12000)
    begin
      mismatches++;
      hung = 1'b1;
      return;
    end
    check(20'(addr), 20'(i > 0));
    check(tout, 20'(tp));
    tp = (prm.lag + tp) * 250 + 1;
    check(20'(n - 1 >= tp - 3 && n - 1 <= tp + 3), 20'h1);
    check(20'(gb), 20'h0);
    if (i > 0)
    begin
      check(hold, 20'(hd));
      hd = (prm.lag + hd) * 250 + 1;
      check(20'(th - 1 >= hd - 3 && th - 1 <= hd + 3), 20'h1);
    end
    else
      check(20'(th), 20'h0);
    tick(3);
    check(20'(grant), 20'h1);
  endtask : frame

  initial
  begin : main
    int         k, b;
    logic [2:0] a;
    logic       t;
    clk = 1'b0;
    hung = 1'b0;
    rst = 1'b1;
    seed = 72;
    mismatches = 0;
    n_compared = 0;
    mv = 1'b0;
    pkt = 1'b0;
    txr = 1'b1;
    fe = 1'b0;
    snd = 1'b0;
    rtx = 1'b0;
    act = 3'h0;
    own = 8'h20;
    meas = 20'h00000;
    dst = '0;
    dv = 16'h0000;
    prm = '{20'h1, 20'h2, 20'h5, 20'h1, 20'h1, 20'h1, 20'h2,
            20'h3};
    tick(15);
    check(20'({busy, grant, hexp, texp, addr}), 20'h0);
    tick(1);
    rst = 1'b0;
    tick(2);
    for (k = 0; k < 16; k++)
    begin
      a = (k < 8) ? 3'(k) : 3'($random(seed));
      t = (k < 8) ? 1'b1 : 1'($random(seed));
      act <= a;
      txr <= t;
      tick(2);
      check(20'(busy), 20'(a[0] | a[1]));
      check(20'(busy & ~a[0]), 20'(a[1] & ~a[0]));
      tick(1);
      check(20'(grant), 20'(t && !(a[0] | a[1])));
    end
    act <= 3'h0;
    txr <= 1'b1;
    for (k = 0; k < 4; k++)
    begin
      pkt = (k == 1 || k == 2);
      mv = (k == 3);
      prm.busy_param = (k == 2) ? 20'h5 : 20'h493e0;
      meas = 20'($random(seed));
      tick(2);
      b = (pkt && prm.busy_param > 250000) ? 250000 : prm.busy_param;
      b = mv ? meas : prm.preamble + prm.lag + b + prm.tolerance_time;
      check(dtm, 20'(b));
    end
    tick(2);
    for (k = 0; k < 6 && !hung; k++)
      frame(k[0], k[1]);
    give_verdict;
  end
endmodule : tb_net_access_busy_and_hold_timers
